// *** src/nbmio_dev.sv ***
// address latch, transfer logic and port write fifo of the interface set
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// small flop fifo
// ----------------------------------------------------------------------------
module nbmio_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    // full and empty straight from the occupancy count
    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage, written by index
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data;
    end

    // pointers and count; depth is a power of two so pointers wrap freely
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= rd_ptr_q + 1'b1;
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end
endmodule

// ----------------------------------------------------------------------------
// device end: address chip and transfer chip together
// ----------------------------------------------------------------------------
module nbmio_dev (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // processor link
    nbmio_if.dev link,
    // program memory side
    output logic [7:0] low_addr_out,
    output logic [3:0] page_select_out,
    output logic half_select,
    output logic progmem_write_n,
    input wire logic [7:0] instr_byte_in,
    // port side
    input wire logic [3:0] port_nibble_in,
    output logic [3:0] port_nibble_out,
    output logic port_nibble_oe,
    output logic port_read_n,
    output logic port_write_n,
    input wire logic port_accept
);
    import nbmio_pkg::*;

    nbmio_phase_t phase_q;
    nbmio_op_t op_q;
    logic fetch_q;
    logic pas_lo_q;
    logic [3:0] opr_q;
    logic [7:0] prog_lo_q;
    logic [7:0] port_addr_q;
    logic [3:0] port_data_q;
    logic port_write_n_q;
    logic [7:0] low_addr_q;
    logic [3:0] page_q;
    logic half_q;
    logic prog_wr_n_q;
    logic [3:0] bus;
    logic pgw_now;
    logic fifo_in_valid;
    logic fifo_out_valid;
    logic [3:0] fifo_out_data;
    logic drain;

    assign bus = link.cpu_nibble_bus;

    // phase tracker: the marker during the last phase restarts the cycle
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            phase_q <= PH_AL;
        else if (link.tick)
        begin
            if (link.sync)
                phase_q <= PH_AL;
            else
            begin
                case (phase_q)
                    PH_AL: phase_q <= PH_AH;
                    PH_AH: phase_q <= PH_PG;
                    PH_PG: phase_q <= PH_IH;
                    PH_IH: phase_q <= PH_IL;
                    PH_IL: phase_q <= PH_E1;
                    PH_E1: phase_q <= PH_E2;
                    PH_E2: phase_q <= PH_E3;
                    default: phase_q <= PH_AL;
                endcase
            end
        end
    end

    // write-progmem command seen in the second memory phase with the command line up
    assign pgw_now = link.rom_cmd && (opr_q == OPR_IO) && (bus == OPA_PGW);

    // program address capture and instruction decode
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            prog_lo_q <= 8'h00;
            fetch_q <= 1'b0;
            opr_q <= 4'h0;
            op_q <= OP_NONE;
        end
        else if (link.tick)
        begin
            case (phase_q)
                PH_AL: prog_lo_q[3:0] <= bus;
                PH_AH: prog_lo_q[7:4] <= bus;
                PH_PG: fetch_q <= link.rom_cmd;
                PH_IH: opr_q <= bus;
                PH_IL:
                begin
                    op_q <= OP_NONE;
                    if (link.rom_cmd && opr_q == OPR_IO)
                    begin
                        case (bus)
                            OPA_RDP: op_q <= OP_RDP;
                            OPA_WRP: op_q <= OP_WRP;
                            OPA_PGW: op_q <= OP_PGW;
                            default: op_q <= OP_NONE;
                        endcase
                    end
                end
                PH_E3: op_q <= OP_NONE;
                default: fetch_q <= fetch_q;
            endcase
        end
    end

    // port address register: high nibble in exec second, low in exec third
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            port_addr_q <= 8'h00;
            pas_lo_q <= 1'b0;
        end
        else if (link.tick)
        begin
            pas_lo_q <= 1'b0;
            if (phase_q == PH_E2 && link.rom_cmd)
            begin
                port_addr_q[7:4] <= bus;
                pas_lo_q <= 1'b1;
            end
            else if (phase_q == PH_E3 && pas_lo_q)
                port_addr_q[3:0] <= bus;
        end
    end

    // address outputs: program address from the first memory phase,
    // port address from the first execute phase
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            low_addr_q <= 8'h00;
            page_q <= 4'h0;
        end
        else if (link.tick && phase_q == PH_PG)
        begin
            low_addr_q <= prog_lo_q;
            page_q <= bus;
        end
        else if (link.tick && phase_q == PH_IL)
        begin
            low_addr_q <= port_addr_q;
            page_q <= pgw_now ? PAGE_PGW : port_addr_q[7:4];
        end
    end

    // program write strobe spans the execute phases of the write
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            prog_wr_n_q <= 1'b1;
        else if (link.tick && phase_q == PH_IL)
            prog_wr_n_q <= !pgw_now;
        else if (link.tick && phase_q == PH_E3)
            prog_wr_n_q <= 1'b1;
    end

    // half select flips after each program write completes
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            half_q <= HALF_RESET;
        else if (link.tick && phase_q == PH_E3 && op_q == OP_PGW)
            half_q <= !half_q;
    end

    assign low_addr_out = low_addr_q;
    assign page_select_out = page_q;
    assign half_select = half_q;
    assign progmem_write_n = prog_wr_n_q;

    // nibble bus drive: instruction halves, or port input on a read
    always_comb
    begin
        link.dev_d = port_nibble_in;
        link.dev_d_oe = 1'b0;
        if (fetch_q && phase_q == PH_IH)
        begin
            link.dev_d = instr_byte_in[7:4];
            link.dev_d_oe = 1'b1;
        end
        else if (fetch_q && phase_q == PH_IL)
        begin
            link.dev_d = instr_byte_in[3:0];
            link.dev_d_oe = 1'b1;
        end
        else if (phase_q == PH_E2 && op_q == OP_RDP)
            link.dev_d_oe = 1'b1;
    end

    // read strobe for the whole second execute phase
    assign port_read_n = !(phase_q == PH_E2 && op_q == OP_RDP);

    // write data goes through the fifo; a full fifo stalls the processor
    assign fifo_in_valid = link.tick && phase_q == PH_E2
        && (op_q == OP_WRP || op_q == OP_PGW);
    assign drain = fifo_out_valid && port_accept;

    nbmio_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) nbmio_fifo_i (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(link.out_ready),
        .in_data(bus),
        .out_valid(fifo_out_valid),
        .out_ready(port_accept),
        .out_data(fifo_out_data)
    );

    // port data and one-cycle write strobe together
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            port_data_q <= 4'h0;
            port_write_n_q <= 1'b1;
        end
        else
        begin
            port_write_n_q <= !drain;
            if (drain)
                port_data_q <= fifo_out_data;
        end
    end

    assign port_nibble_out = port_data_q;
    assign port_write_n = port_write_n_q;
    // released while the input port owns the bus
    assign port_nibble_oe = port_read_n;
endmodule

// *** pkg/nbmio_pkg.sv ***
// shared constants and types for the nibble bus memory and port interface set
// ----------------------------------------------------------------------------
// Notes on behaviour
// - latch low address nibbles at first two phases
// - latch page nibble at third address phase
// - drive low address and page select outputs
// - outside logic decodes page select to one page
// - return instruction byte as two nibbles
// - fetch transfer only when command line asserted
// - send-register-control stores eight bit port address
// - port address shown on outputs at exec first
// - outside logic decodes page select for ports
// - read port drives active-low read strobe
// - read port passes port bus onto nibble bus
// - write port drives processor nibble to port
// - write port pulses active-low write strobe
// - half-select output marks nibble being written
// - program write output low on write-progmem
// - cycle marker synchronises both ends
// - command line decodes port and register commands
// - everything travels on shared nibble bus
// - instruction inputs, highest bit most significant
// - write-progmem forces page select to all ones
// - half-select starts high, toggles per write-progmem
// - write-progmem nibble reaches port bus at exec second; here it goes through the fifo to the port once drained
// ----------------------------------------------------------------------------
package nbmio_pkg;
    // phase timing: one processor clock period per phase
    localparam int PHASE_TIME_NS = 1350;
    localparam int CLK_PERIOD_NS = 40;
    localparam int PHASE_CYCLES = (PHASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 6;

    // instruction encodings seen on the nibble bus
    localparam logic [3:0] OPR_IO = 4'hE;
    localparam logic [3:0] OPR_PAS = 4'h2;
    localparam logic [3:0] OPA_WRP = 4'h2;
    localparam logic [3:0] OPA_PGW = 4'h3;
    localparam logic [3:0] OPA_RDP = 4'hA;

    // fixed values
    localparam logic [3:0] PAGE_PGW = 4'hF;
    localparam logic HALF_RESET = 1'b1;
    localparam logic [3:0] BUS_IDLE = 4'hF;
    localparam int FIFO_WIDTH = 4;
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [2:0] {PH_AL, PH_AH, PH_PG, PH_IH, PH_IL, PH_E1, PH_E2, PH_E3}
        nbmio_phase_t;
    typedef enum logic [2:0] {OP_NONE, OP_PAS, OP_RDP, OP_WRP, OP_PGW} nbmio_op_t;
endpackage

// *** pkg/nbmio_if.sv ***
// link between processor end and memory/port interface end
`timescale 1ns/10ps
interface nbmio_if;
    logic tick;
    logic sync;
    logic rom_cmd;
    logic [3:0] cpu_d;
    logic cpu_d_oe;
    logic [3:0] dev_d;
    logic dev_d_oe;
    logic out_ready;
    logic [3:0] cpu_nibble_bus;

    // shared nibble bus resolved from the enables, idle level when nobody drives
    assign cpu_nibble_bus = dev_d_oe ? dev_d : (cpu_d_oe ? cpu_d : nbmio_pkg::BUS_IDLE);

    modport cpu (output tick, sync, rom_cmd, cpu_d, cpu_d_oe, input cpu_nibble_bus, out_ready);
    modport dev (input tick, sync, rom_cmd, cpu_nibble_bus, output dev_d, dev_d_oe, out_ready);
endinterface

// *** src/nbmio_cpu.sv ***
// processor end: phase generator, address sender and executor of port commands
`timescale 1ns/10ps
module nbmio_cpu (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // link to the interface set
    nbmio_if.cpu link,
    // user side
    input wire logic [7:0] pas_addr,
    input wire logic [3:0] wr_nibble,
    output logic [7:0] instr_out,
    output logic instr_valid,
    output logic [3:0] rd_data,
    output logic rd_valid,
    output logic [11:0] pc_out
);
    import nbmio_pkg::*;

    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(PHASE_CYCLES - 1);

    nbmio_phase_t phase_q;
    nbmio_op_t op_q;
    logic [DIV_W-1:0] div_q;
    logic [11:0] pc_q;
    logic [3:0] opr_q;
    logic [7:0] instr_q;
    logic instr_valid_q;
    logic [3:0] rd_data_q;
    logic rd_valid_q;
    logic stall;
    logic tick;
    logic [3:0] bus;

    assign bus = link.cpu_nibble_bus;

    // a port write waits in exec second until the fifo has room
    assign stall = phase_q == PH_E2 && (op_q == OP_WRP || op_q == OP_PGW) && !link.out_ready;
    assign tick = (div_q == DIV_MAX) && !stall;
    assign link.tick = tick;
    assign link.sync = (phase_q == PH_E3);

    // phase divider, holds at the end count while stalled
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            div_q <= '0;
        else if (tick)
            div_q <= '0;
        else if (div_q != DIV_MAX)
            div_q <= div_q + 1'b1;
    end

    // phase sequence and program counter
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            phase_q <= PH_AL;
            pc_q <= 12'h000;
        end
        else if (tick)
        begin
            case (phase_q)
                PH_AL: phase_q <= PH_AH;
                PH_AH: phase_q <= PH_PG;
                PH_PG: phase_q <= PH_IH;
                PH_IH: phase_q <= PH_IL;
                PH_IL: phase_q <= PH_E1;
                PH_E1: phase_q <= PH_E2;
                PH_E2: phase_q <= PH_E3;
                default:
                begin
                    phase_q <= PH_AL;
                    pc_q <= pc_q + 12'h001;
                end
            endcase
        end
    end

    // fetched instruction and its decode
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            opr_q <= 4'h0;
            op_q <= OP_NONE;
            instr_q <= 8'h00;
            instr_valid_q <= 1'b0;
        end
        else
        begin
            instr_valid_q <= 1'b0;
            if (tick && phase_q == PH_IH)
                opr_q <= bus;
            else if (tick && phase_q == PH_IL)
            begin
                instr_q <= {opr_q, bus};
                instr_valid_q <= 1'b1;
                op_q <= OP_NONE;
                if (opr_q == OPR_PAS && bus[0])
                    op_q <= OP_PAS;
                else if (opr_q == OPR_IO && bus == OPA_RDP)
                    op_q <= OP_RDP;
                else if (opr_q == OPR_IO && bus == OPA_WRP)
                    op_q <= OP_WRP;
                else if (opr_q == OPR_IO && bus == OPA_PGW)
                    op_q <= OP_PGW;
            end
            else if (tick && phase_q == PH_E3)
                op_q <= OP_NONE;
        end
    end

    // port read data taken at the end of exec second
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rd_data_q <= 4'h0;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= tick && phase_q == PH_E2 && op_q == OP_RDP;
            if (tick && phase_q == PH_E2 && op_q == OP_RDP)
                rd_data_q <= bus;
        end
    end

    // command line: fetch in PG, port group in IL, register send in E2
    assign link.rom_cmd = (phase_q == PH_PG) || (phase_q == PH_IL && opr_q == OPR_IO)
        || (phase_q == PH_E2 && op_q == OP_PAS);

    // nibble bus drive for addresses and data
    always_comb
    begin
        link.cpu_d = 4'h0;
        link.cpu_d_oe = 1'b1;
        case (phase_q)
            PH_AL: link.cpu_d = pc_q[3:0];
            PH_AH: link.cpu_d = pc_q[7:4];
            PH_PG: link.cpu_d = pc_q[11:8];
            PH_E2:
            begin
                if (op_q == OP_PAS)
                    link.cpu_d = pas_addr[7:4];
                else if (op_q == OP_WRP || op_q == OP_PGW)
                    link.cpu_d = wr_nibble;
                else
                    link.cpu_d_oe = 1'b0;
            end
            PH_E3:
            begin
                link.cpu_d = pas_addr[3:0];
                link.cpu_d_oe = (op_q == OP_PAS);
            end
            default: link.cpu_d_oe = 1'b0;
        endcase
    end

    assign instr_out = instr_q;
    assign instr_valid = instr_valid_q;
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign pc_out = pc_q;
endmodule

// *** testbench/nbmio_chk.sv ***
// link checker for the nibble bus interface set, watching the shared interface signals
`timescale 1ns/10ps
module nbmio_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // processor drive
    input wire logic tick,
    input wire logic sync,
    input wire logic rom_cmd,
    input wire logic cpu_d_oe,
    // device drive
    input wire logic dev_d_oe,
    input wire logic out_ready,
    // resolved bus
    input wire logic [3:0] cpu_nibble_bus
);
    import nbmio_pkg::*;

    logic [2:0] ph_q;
    logic [11:0] cnt_q;
    logic fetch_q;
    logic [3:0] opr_q;
    logic rdp_q;
    logic wr_q;
    logic pas_q;

    // -------------------------------------------------------------------
    // helper phase tracking
    // -------------------------------------------------------------------
    // phase index 0..7 = AL AH PG IH IL E1 E2 E3, realigned by the marker
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ph_q <= 3'd0;
        else if (tick)
            ph_q <= sync ? 3'd0 : ph_q + 3'd1;
    end

    // cycles since the last tick; wide so a stalled X2 cannot wrap
    always_ff @(posedge clk_sys)
    begin
        if (rst || tick)
            cnt_q <= 12'h000;
        else
            cnt_q <= cnt_q + 12'h001;
    end

    // decode of the fetched instruction as seen on the bus
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            fetch_q <= 1'b0;
            opr_q <= 4'h0;
            rdp_q <= 1'b0;
            wr_q <= 1'b0;
            pas_q <= 1'b0;
        end
        else if (tick && ph_q == 3'd2)
            fetch_q <= rom_cmd;
        else if (tick && ph_q == 3'd3)
            opr_q <= cpu_nibble_bus;
        else if (tick && ph_q == 3'd4)
        begin
            rdp_q <= rom_cmd && opr_q == OPR_IO && cpu_nibble_bus == OPA_RDP;
            wr_q <= rom_cmd && opr_q == OPR_IO &&
                (cpu_nibble_bus == OPA_WRP || cpu_nibble_bus == OPA_PGW);
            pas_q <= opr_q == OPR_PAS && cpu_nibble_bus[0];
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    property p_tick_pulse;
        tick |=> !tick [*8];
    endproperty
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("tick not a lone pulse");

    property p_phase_len;
        tick && ph_q != 3'd6 |-> cnt_q == PHASE_CYCLES - 1;
    endproperty
    a_phase_len: assert property (p_phase_len)
        else $error("phase length wrong");

    property p_x2_len;
        tick && ph_q == 3'd6 |-> cnt_q >= PHASE_CYCLES - 1;
    endproperty
    a_x2_len: assert property (p_x2_len)
        else $error("execute phase cut short");

    property p_sync_x3;
        1'b1 |-> sync == (ph_q == 3'd7);
    endproperty
    a_sync_x3: assert property (p_sync_x3)
        else $error("cycle marker outside last phase");

    property p_rom_a3;
        ph_q == 3'd2 |-> rom_cmd;
    endproperty
    a_rom_a3: assert property (p_rom_a3)
        else $error("command line low in third address phase");

    property p_addr_drive;
        ph_q <= 3'd2 |-> cpu_d_oe && !dev_d_oe;
    endproperty
    a_addr_drive: assert property (p_addr_drive)
        else $error("address phase bus owner wrong");

    property p_fetch_drive;
        ph_q == 3'd3 || ph_q == 3'd4 |-> dev_d_oe == fetch_q;
    endproperty
    a_fetch_drive: assert property (p_fetch_drive)
        else $error("memory phase drive not tied to command");

    property p_exec_quiet;
        ph_q == 3'd5 || ph_q == 3'd7 |-> !dev_d_oe;
    endproperty
    a_exec_quiet: assert property (p_exec_quiet)
        else $error("device drives bus in processor phase");

    property p_rdp_drive;
        ph_q == 3'd6 && rdp_q |-> dev_d_oe;
    endproperty
    a_rdp_drive: assert property (p_rdp_drive)
        else $error("port read not passed to bus");

    property p_wr_hold;
        ph_q == 3'd6 && wr_q && !out_ready |-> !tick;
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write advanced with buffer full");

    property p_pas_cmd;
        ph_q == 3'd6 && pas_q |-> rom_cmd;
    endproperty
    a_pas_cmd: assert property (p_pas_cmd)
        else $error("port address send without command");
endmodule

// *** testbench/nbmio_tb.sv ***
// self-checking bench joining processor end and device end of the interface set
`timescale 1ns/10ps
`define CHK_EQ(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH at %0t ns: %s", $time, msg); end end
module nibble_bus_memory_io_interface_tb;
    import nbmio_pkg::*;

    logic clk_sys;
    logic rst;
    logic [7:0] pas_addr;
    logic [3:0] wr_nibble;
    logic [7:0] instr_out;
    logic instr_valid;
    logic [3:0] rd_data;
    logic rd_valid;
    logic [7:0] low_addr_out;
    logic [3:0] page_select_out;
    logic half_select;
    logic progmem_write_n;
    logic [7:0] instr_byte_in;
    logic [3:0] port_nibble_in;
    logic [3:0] port_nibble_out;
    logic port_nibble_oe;
    logic port_read_n;
    logic port_write_n;
    logic port_accept;
    int n_mismatch;
    int comparisons;
    int cyc;
    int n_rd;
    int n_rd_low;
    int n_wpm;
    int n_port_wr;
    int exp_pc;
    logic exp_half;
    logic prog_prev;
    logic [3:0] exp_q[$];
    logic [7:0] rom[4096];

    nbmio_if nbmio_if_i ();

    nbmio_cpu nbmio_cpu_i (.clk_sys(clk_sys), .rst(rst), .link(nbmio_if_i),
        .pas_addr(pas_addr), .wr_nibble(wr_nibble), .instr_out(instr_out),
        .instr_valid(instr_valid), .rd_data(rd_data), .rd_valid(rd_valid), .pc_out());

    nbmio_dev nbmio_dev_i (.clk_sys(clk_sys), .rst(rst), .link(nbmio_if_i),
        .low_addr_out(low_addr_out), .page_select_out(page_select_out),
        .half_select(half_select), .progmem_write_n(progmem_write_n),
        .instr_byte_in(instr_byte_in), .port_nibble_in(port_nibble_in),
        .port_nibble_out(port_nibble_out), .port_nibble_oe(port_nibble_oe),
        .port_read_n(port_read_n), .port_write_n(port_write_n), .port_accept(port_accept));

    nbmio_chk nbmio_chk_i (.clk_sys(clk_sys), .rst(rst), .tick(nbmio_if_i.tick),
        .sync(nbmio_if_i.sync), .rom_cmd(nbmio_if_i.rom_cmd), .cpu_d_oe(nbmio_if_i.cpu_d_oe),
        .dev_d_oe(nbmio_if_i.dev_d_oe), .out_ready(nbmio_if_i.out_ready),
        .cpu_nibble_bus(nbmio_if_i.cpu_nibble_bus));

    // program memory model, addressed by page and low address
    assign instr_byte_in = rom[{page_select_out, low_addr_out}];

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    // -------------------------------------------------------------------
    // closing report
    // -------------------------------------------------------------------
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard: whole program needs well under half of this
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t ns: run timed out", $time);
            give_verdict();
        end
    end

    // -------------------------------------------------------------------
    // pin monitor and write data source
    // -------------------------------------------------------------------
    // new write nibble per fetched write, so every queued value differs
    always @(posedge clk_sys)
    begin
        #1;
        if (rst === 1'b0)
        begin
            if (instr_valid === 1'b1)
            begin
                `CHK_EQ(instr_out, rom[exp_pc], "fetched byte")
                if (rom[exp_pc] == 8'hE2 || rom[exp_pc] == 8'hE3)
                begin
                    wr_nibble = wr_nibble + 4'h3;
                    exp_q.push_back(wr_nibble);
                end
                exp_pc++;
            end
            if (rd_valid === 1'b1)
            begin
                n_rd++;
                `CHK_EQ(rd_data, port_nibble_in, "port read data")
                `CHK_EQ(low_addr_out, 8'hA5, "port address low")
                `CHK_EQ(page_select_out, 4'hA, "port address page")
            end
            if (port_read_n === 1'b0)
            begin
                n_rd_low++;
                `CHK_EQ(nbmio_if_i.cpu_nibble_bus, port_nibble_in, "read bus path")
                `CHK_EQ(port_nibble_oe, 1'b0, "port bus not released")
            end
            if (port_write_n === 1'b0)
            begin
                n_port_wr++;
                `CHK_EQ(port_nibble_out, exp_q.size() ? exp_q.pop_front() : 4'hX, "wr data")
            end
            if (progmem_write_n !== prog_prev && progmem_write_n === 1'b0)
            begin
                n_wpm++;
                `CHK_EQ(page_select_out, PAGE_PGW, "program write page")
                `CHK_EQ(low_addr_out, 8'hA5, "program write address")
            end
            else if (progmem_write_n !== prog_prev)
            begin
                exp_half = ~exp_half;
                `CHK_EQ(half_select, exp_half, "half select toggle")
            end
            prog_prev = progmem_write_n;
        end
    end

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        rst = 1'b1;
        pas_addr = 8'hA5;
        wr_nibble = 4'h0;
        port_nibble_in = 4'h9;
        port_accept = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        cyc = 0;
        n_rd = 0;
        n_rd_low = 0;
        n_wpm = 0;
        n_port_wr = 0;
        exp_pc = 0;
        exp_half = HALF_RESET;
        prog_prev = 1'b1;
        // filler bytes decode to nothing and carry the low address nibble
        for (int i = 0; i < 4096; i++)
            rom[i] = {4'h1, i[3:0]};
        rom[0] = 8'h21;
        rom[1] = 8'hEA;
        for (int i = 2; i < 7; i++)
            rom[i] = 8'hE2;
        rom[7] = 8'hE3;
        rom[8] = 8'hE3;
        repeat (10) @(posedge clk_sys);
        #1 rst = 1'b0;
        @(negedge clk_sys);
        `CHK_EQ(half_select, 1'b1, "half select reset")
        `CHK_EQ(progmem_write_n, 1'b1, "program write idle")
        `CHK_EQ(port_write_n, 1'b1, "port write idle")
        `CHK_EQ(port_read_n, 1'b1, "port read idle")
        $display("test reset values done");

        // five writes with the port stalled: four fit, the fifth is held
        for (int i = 0; i < 6000 && nbmio_if_i.out_ready !== 1'b0; i++)
            @(negedge clk_sys);
        repeat (300) @(negedge clk_sys);
        `CHK_EQ(nbmio_if_i.out_ready, 1'b0, "buffer not refusing")
        `CHK_EQ(n_port_wr, 0, "port written while stalled")
        `CHK_EQ(exp_q.size(), 5, "writes fetched before stall")
        $display("test buffer fill done");

        // drain, then two program writes through the same path
        @(posedge clk_sys);
        #1 port_accept = 1'b1;
        for (int i = 0; i < 6000 && !(n_wpm == 2 && prog_prev === 1'b1 && exp_q.size() == 0); i++)
            @(negedge clk_sys);
        `CHK_EQ(n_rd, 1, "port read count")
        `CHK_EQ(n_rd_low, PHASE_CYCLES, "read strobe length")
        `CHK_EQ(n_wpm, 2, "program write count")
        `CHK_EQ(n_port_wr, 7, "port strobes")
        `CHK_EQ(half_select, 1'b1, "half select after two")
        $display("test drain and program write done");
        give_verdict();
    end
endmodule
